// ===== rtl/aqh_pkg.sv
// Constants, field layout and carrier types of the asynchronous queue host port
//==============================================================================
// Overview of operation
// RL1 - Next write pushes request quadlet, not last
// RL2 - Last write pushes request quadlet, closes packet
// RL3 - Request write clears written flag until moved
// RL4 - Response next write pushes, clears written flag
// RL5 - Response last write pushes closing quadlet
// RL6 - Request read clears quadlet-ready until next load
// RL7 - Response read clears quadlet-ready until next load
// RL8 - Latch became-full flag for all four queues
// RL9 - Flag self-identification quadlet in request register
// RL10 - Flag final quadlet per receive register
// RL11 - Error or bus reset blocks receive reads
// RL12 - Flag quadlet ready per receive register
// RL13 - Flag split transaction timeout
// RL14 - Flag solicited reply inside timeout
// RL15 - Flag transmit write fault per queue
// RL16 - Flag written once transfer register empties
// RL17 - Event bits 31 to 17 read zero
// RL18 - Enable bit per event, both reset zero
// RL19 - Timeout is seconds plus eighth-millisecond ticks
// RL20 - Interrupt while flag and enable set; W1C
// RL21 - Host writes next quadlets, one last, waits
//==============================================================================
package aqh_pkg;

	// Bus and word widths
	localparam int ADDR_W    = 9;
	localparam int BYTE_W    = 8;
	localparam int WORD_W    = 32;
	localparam int EVENT_W   = 17;
	localparam int CH_N      = 2;

	// Register byte addresses
	localparam logic [8:0] OFS_TXREQ_NEXT = 9'h088;
	localparam logic [8:0] OFS_TXREQ_LAST = 9'h08C;
	localparam logic [8:0] OFS_TXRSP_NEXT = 9'h090;
	localparam logic [8:0] OFS_TXRSP_LAST = 9'h094;
	localparam logic [8:0] OFS_RXREQ      = 9'h098;
	localparam logic [8:0] OFS_RXRSP      = 9'h09C;
	localparam logic [8:0] OFS_FLAGS      = 9'h0A0;
	localparam logic [8:0] OFS_ENABLES    = 9'h0A4;

	// Byte lane whose write commits a quadlet or whose read consumes one
	localparam logic [1:0] LANE_LAST = 2'h3;

	// Event bit positions; per-queue pairs add the channel (0 request, 1 response)
	localparam int BIT_TX_WRITTEN   = 0;
	localparam int BIT_TX_FAULT     = 2;
	localparam int BIT_TX_FULL      = 4;
	localparam int BIT_REPLY        = 6;
	localparam int BIT_TIMEOUT      = 7;
	localparam int BIT_RX_READY     = 8;
	localparam int BIT_RX_FAULT     = 10;
	localparam int BIT_RX_FINAL     = 12;
	localparam int BIT_SELF_IDENT   = 14;
	localparam int BIT_RX_FULL      = 15;

	// Reset values
	localparam logic [16:0] FLAGS_RESET   = 17'h00000;
	localparam logic [16:0] ENABLES_RESET = 17'h00000;
	localparam logic [31:0] QUADLET_RESET = 32'h00000000;

	// Timeout timing: one fraction tick is 1/8000 s
	localparam int CLK_PERIOD_NS    = 4;
	localparam int TICK_PERIOD_NS   = 125000;
	localparam int TICK_CYCLES      = (TICK_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int SECONDS_W        = 3;
	localparam int FRACTION_W       = 13;
	localparam int TICKS_W          = 16;
	localparam logic [15:0] TICKS_PER_SECOND = 16'h1F40;
	localparam int DIV_W            = 16;

	// Transmit quadlet toward the queue logic
	typedef struct packed {
		logic        last;
		logic [31:0] data;
	} aqh_txq_type;

	// Receive quadlet from the queue logic
	typedef struct packed {
		logic        self_ident;
		logic        last;
		logic [31:0] data;
	} aqh_rxq_type;

	// Host pins after synchronisation
	typedef struct packed {
		logic [8:0] addr;
		logic [7:0] data;
		logic       cs_n;
		logic       wr_n;
		logic       rd_n;
	} aqh_pins_type;

	localparam aqh_pins_type PINS_IDLE = '{addr: 9'h000, data: 8'h00,
		cs_n: 1'b1, wr_n: 1'b1, rd_n: 1'b1};

endpackage

// ===== rtl/aqh_port.sv
// Host register port for the asynchronous transmit and receive queues
`timescale 1ns/100ps
module aqh_port #(
	parameter int TICK_CYCLES = aqh_pkg::TICK_CYCLES
) (
	// Clock and reset
	input  wire logic                        REF_CLK,
	input  wire logic                        RSTN,
	// Byte-wide host bus
	input  wire logic [aqh_pkg::ADDR_W-1:0]  HIF_ADDR,
	input  wire logic                        HIF_CS_N,
	input  wire logic                        HIF_WR_N,
	input  wire logic                        HIF_RD_N,
	input  wire logic [aqh_pkg::BYTE_W-1:0]  HIF_DATA_IN,
	output logic      [aqh_pkg::BYTE_W-1:0]  HIF_DATA_OUT,
	output logic                             HIF_DATA_OE_N,
	output logic                             HIF_INT_N,
	// Transmit queues, index 0 request, 1 response
	output wire aqh_pkg::aqh_txq_type [1:0]  TX_QUADLET,
	output wire logic [1:0]                  TX_VALID,
	input  wire logic [1:0]                  TX_READY,
	input  wire logic [1:0]                  TX_QUEUE_FULL,
	input  wire logic [1:0]                  TX_WRITE_ERROR,
	// Receive queues, index 0 request, 1 response
	input  wire aqh_pkg::aqh_rxq_type [1:0]  RX_QUADLET,
	input  wire logic [1:0]                  RX_VALID,
	output wire logic [1:0]                  RX_READY,
	input  wire logic [1:0]                  RX_QUEUE_FULL,
	input  wire logic [1:0]                  RX_READ_ERROR,
	input  wire logic                        BUS_RESET,
	// Split transaction timer
	input  wire logic                        SPLIT_START,
	input  wire logic                        SOLICITED_REPLY,
	input  wire logic [aqh_pkg::SECONDS_W-1:0]  TIMEOUT_WHOLE_SECONDS,
	input  wire logic [aqh_pkg::FRACTION_W-1:0] TIMEOUT_FRACTION_TICKS
);
	import aqh_pkg::*;

	//==========================================================================
	// Helpers
	//==========================================================================
	// Word-aligned base of a byte address
	function automatic logic [8:0] base_of(input logic [8:0] a);
		base_of = {a[8:2], 2'h0};
	endfunction

	// Byte of a word picked by lane
	function automatic logic [7:0] lane_of(input logic [31:0] w, input logic [1:0] l);
		lane_of = w[{l, 3'h0} +: 8];
	endfunction

	//==========================================================================
	// Host pin synchroniser and strobe tracking
	//==========================================================================
	aqh_pins_type pin_s1;
	aqh_pins_type pin_s2;
	aqh_pins_type pin_now;
	logic         wr_act_d;
	logic         rd_act_d;
	logic [8:0]   cap_addr;
	logic [7:0]   cap_data;
	logic [23:0]  stage;
	logic         wr_act;
	logic         rd_act;
	logic         wr_end;
	logic         rd_end;
	logic [8:0]   cap_base;
	logic [31:0]  commit_word;

	assign pin_now = '{addr: HIF_ADDR, data: HIF_DATA_IN, cs_n: HIF_CS_N,
		wr_n: HIF_WR_N, rd_n: HIF_RD_N};

	// Two stages before any logic looks at the pins
	always_ff @(posedge REF_CLK) begin
		if (!RSTN) begin
			pin_s1 <= PINS_IDLE;
			pin_s2 <= PINS_IDLE;
		end else begin
			pin_s1 <= pin_now;
			pin_s2 <= pin_s1;
		end
	end

	assign wr_act = !pin_s2.cs_n && !pin_s2.wr_n;
	assign rd_act = !pin_s2.cs_n && !pin_s2.rd_n;
	assign wr_end = wr_act_d && !wr_act;
	assign rd_end = rd_act_d && !rd_act;
	assign cap_base = base_of(cap_addr);
	assign commit_word = {cap_data, stage};

	// Capture address and data while a strobe is active; act when it ends,
	// since the data pins only settle late in a write
	always_ff @(posedge REF_CLK) begin
		if (!RSTN) begin
			wr_act_d <= 1'b0;
			rd_act_d <= 1'b0;
			cap_addr <= 9'h000;
			cap_data <= 8'h00;
		end else begin
			wr_act_d <= wr_act;
			rd_act_d <= rd_act;
			if (wr_act || rd_act) begin
				cap_addr <= pin_s2.addr;
				cap_data <= pin_s2.data;
			end
		end
	end

	// Low three bytes wait here until the top byte commits the quadlet
	always_ff @(posedge REF_CLK) begin
		if (!RSTN) begin
			stage <= 24'h000000;
		end else if (wr_end && cap_addr[1:0] != LANE_LAST) begin
			stage[{cap_addr[1:0], 3'h0} +: 8] <= cap_data;
		end
	end

	//==========================================================================
	// Event flags and enables
	//==========================================================================
	logic [16:0] flags;
	logic [16:0] enables;
	wire  [16:0] ev_set;
	wire  [16:0] ev_hw_clr;
	logic [16:0] ev_host_clr;
	logic [31:0] host_mask;

	// Lane mask for one host byte write
	always_comb begin
		host_mask = 32'h00000000;
		host_mask[{cap_addr[1:0], 3'h0} +: 8] = cap_data;
	end

	always_comb begin
		ev_host_clr = 17'h00000;
		if (wr_end && cap_base == OFS_FLAGS) begin
			ev_host_clr = host_mask[16:0]; // [RL20]
		end
	end

	// Hardware set wins over any clear in the same cycle
	always_ff @(posedge REF_CLK) begin
		if (!RSTN) begin
			flags <= FLAGS_RESET; // [RL18]
		end else begin
			flags <= (flags & ~(ev_hw_clr | ev_host_clr)) | ev_set;
		end
	end

	// Enables are plain byte-wide stores
	always_ff @(posedge REF_CLK) begin
		if (!RSTN) begin
			enables <= ENABLES_RESET; // [RL18]
		end else if (wr_end && cap_base == OFS_ENABLES) begin
			enables <= 17'(({15'h0000, enables} & ~(32'h000000FF << {cap_addr[1:0], 3'h0}))
				| host_mask); // [RL18]
		end
	end

	assign ev_hw_clr[7:2]   = 6'h00;
	assign ev_hw_clr[11:10] = 2'h0;
	assign ev_hw_clr[16:15] = 2'h0;

	//==========================================================================
	// Transmit channels: transfer register then two-entry buffer
	//==========================================================================
	wire [1:0] tx_commit;
	wire [1:0] tx_last_write;
	wire [1:0] tx_move;
	wire [1:0] tx_hold_valid;

	for (genvar ch = 0; ch < CH_N; ch++) begin : g_tx
		localparam logic [8:0] OFS_NEXT = (ch == 0) ? OFS_TXREQ_NEXT : OFS_TXRSP_NEXT;
		localparam logic [8:0] OFS_LAST = (ch == 0) ? OFS_TXREQ_LAST : OFS_TXRSP_LAST;
		aqh_txq_type hold;
		logic        hold_valid;
		aqh_txq_type buf_mem [2];
		logic        wp;
		logic        rp;
		logic [1:0]  count;
		logic        full_d;
		wire         hit_next;
		wire         pop;

		assign hit_next = cap_base == OFS_NEXT;
		assign tx_last_write[ch] = cap_base == OFS_LAST;
		assign tx_commit[ch] = wr_end && cap_addr[1:0] == LANE_LAST
			&& (hit_next || tx_last_write[ch]);
		assign tx_move[ch] = hold_valid && count != 2'h2;
		assign tx_hold_valid[ch] = hold_valid;
		assign pop = TX_VALID[ch] && TX_READY[ch];

		// A write into a still-occupied register is dropped and reported
		always_ff @(posedge REF_CLK) begin
			if (!RSTN) begin
				hold_valid <= 1'b0;
				hold       <= '0;
			end else if (tx_commit[ch] && !hold_valid) begin
				hold_valid <= 1'b1;
				hold       <= '{last: tx_last_write[ch], data: commit_word}; // [RL1] [RL2] [RL4] [RL5]
			end else if (tx_move[ch]) begin
				hold_valid <= 1'b0;
			end
		end

		// Buffer absorbs a stalled queue without losing a word
		always_ff @(posedge REF_CLK) begin
			if (!RSTN) begin
				wp    <= 1'b0;
				rp    <= 1'b0;
				count <= 2'h0;
			end else begin
				if (tx_move[ch]) begin
					buf_mem[wp] <= hold;
					wp <= !wp;
				end
				if (pop) begin
					rp <= !rp;
				end
				count <= count + {1'b0, tx_move[ch]} - {1'b0, pop};
			end
		end

		always_ff @(posedge REF_CLK) begin
			if (!RSTN) begin
				full_d <= 1'b0;
			end else begin
				full_d <= TX_QUEUE_FULL[ch];
			end
		end

		assign TX_VALID[ch] = count != 2'h0;
		assign TX_QUADLET[ch] = buf_mem[rp];
		assign ev_set[BIT_TX_WRITTEN + ch] = tx_move[ch]; // [RL16]
		assign ev_hw_clr[BIT_TX_WRITTEN + ch] = tx_commit[ch]; // [RL3] [RL4]
		assign ev_set[BIT_TX_FAULT + ch] = TX_WRITE_ERROR[ch]
			|| (tx_commit[ch] && hold_valid); // [RL15]
		assign ev_set[BIT_TX_FULL + ch] = TX_QUEUE_FULL[ch] && !full_d; // [RL8]
	end

	//==========================================================================
	// Receive channels: transfer register loaded while empty and unblocked
	//==========================================================================
	logic [31:0] rx_word [2];
	wire  [1:0]  rx_load;
	wire  [1:0]  rx_read_done;

	for (genvar ch = 0; ch < CH_N; ch++) begin : g_rx
		localparam logic [8:0] OFS_RX = (ch == 0) ? OFS_RXREQ : OFS_RXRSP;
		logic full_d;

		assign RX_READY[ch] = !flags[BIT_RX_READY + ch] && !flags[BIT_RX_FAULT + ch]; // [RL11]
		assign rx_load[ch] = RX_VALID[ch] && RX_READY[ch];
		assign rx_read_done[ch] = rd_end && cap_base == OFS_RX
			&& cap_addr[1:0] == LANE_LAST && !flags[BIT_RX_FAULT + ch]; // [RL11]

		always_ff @(posedge REF_CLK) begin
			if (!RSTN) begin
				rx_word[ch] <= QUADLET_RESET;
			end else if (rx_load[ch]) begin
				rx_word[ch] <= RX_QUADLET[ch].data; // [RL6] [RL7]
			end
		end

		always_ff @(posedge REF_CLK) begin
			if (!RSTN) begin
				full_d <= 1'b0;
			end else begin
				full_d <= RX_QUEUE_FULL[ch];
			end
		end

		assign ev_set[BIT_RX_READY + ch] = rx_load[ch]; // [RL12]
		assign ev_hw_clr[BIT_RX_READY + ch] = rx_read_done[ch]; // [RL6] [RL7]
		assign ev_set[BIT_RX_FINAL + ch] = rx_load[ch] && RX_QUADLET[ch].last; // [RL10]
		assign ev_hw_clr[BIT_RX_FINAL + ch] = rx_load[ch];
		assign ev_set[BIT_RX_FAULT + ch] = RX_READ_ERROR[ch] || BUS_RESET; // [RL11]
		assign ev_set[BIT_RX_FULL + ch] = RX_QUEUE_FULL[ch] && !full_d; // [RL8]
	end

	// Self-identification only arrives through the request register
	assign ev_set[BIT_SELF_IDENT] = rx_load[0] && RX_QUADLET[0].self_ident; // [RL9]
	assign ev_hw_clr[BIT_SELF_IDENT] = rx_load[0];

	//==========================================================================
	// Split transaction timer
	//==========================================================================
	logic [DIV_W-1:0]   div_cnt;
	logic [TICKS_W-1:0] remaining;
	logic               running;
	logic               tick;
	logic [TICKS_W-1:0] next_remaining;

	// Limit is sampled at start; later changes apply to the next transaction
	assign next_remaining = 16'(TICKS_W'(TIMEOUT_WHOLE_SECONDS) * TICKS_PER_SECOND)
		+ TICKS_W'(TIMEOUT_FRACTION_TICKS); // [RL19]
	assign tick = running && div_cnt == DIV_W'(TICK_CYCLES - 1);

	always_ff @(posedge REF_CLK) begin
		if (!RSTN || SPLIT_START || !running || tick) begin
			div_cnt <= '0;
		end else begin
			div_cnt <= div_cnt + 1'b1;
		end
	end

	always_ff @(posedge REF_CLK) begin
		if (!RSTN) begin
			running   <= 1'b0;
			remaining <= '0;
		end else if (SPLIT_START) begin
			running   <= 1'b1;
			remaining <= next_remaining;
		end else if (running && SOLICITED_REPLY) begin
			running <= 1'b0;
		end else if (tick) begin
			if (remaining == '0) begin
				running <= 1'b0;
			end else begin
				remaining <= remaining - 1'b1;
			end
		end
	end

	assign ev_set[BIT_TIMEOUT] = !SPLIT_START && !SOLICITED_REPLY && tick
		&& remaining == '0; // [RL13]
	assign ev_set[BIT_REPLY] = !SPLIT_START && running && SOLICITED_REPLY; // [RL14]

	//==========================================================================
	// Read path and interrupt
	//==========================================================================
	logic [31:0] read_word;

	// Blocked receive registers read as zero; transmit registers are write-only
	always_comb begin
		read_word = 32'h00000000;
		case (base_of(pin_s2.addr))
			OFS_RXREQ: read_word = flags[BIT_RX_FAULT] ? 32'h00000000 : rx_word[0];
			OFS_RXRSP: read_word = flags[BIT_RX_FAULT + 1] ? 32'h00000000 : rx_word[1];
			OFS_FLAGS: read_word = {15'h0000, flags}; // [RL17]
			OFS_ENABLES: read_word = {15'h0000, enables};
			default: read_word = 32'h00000000;
		endcase
	end

	always_ff @(posedge REF_CLK) begin
		if (!RSTN) begin
			HIF_DATA_OUT  <= 8'h00;
			HIF_DATA_OE_N <= 1'b1;
		end else begin
			HIF_DATA_OUT  <= rd_act ? lane_of(read_word, pin_s2.addr[1:0]) : 8'h00;
			HIF_DATA_OE_N <= !rd_act;
		end
	end

	always_ff @(posedge REF_CLK) begin
		if (!RSTN) begin
			HIF_INT_N <= 1'b1;
		end else begin
			HIF_INT_N <= !(|(flags & enables)); // [RL20]
		end
	end

	//==========================================================================
	// Assertions
	//==========================================================================
	default clocking cb @(posedge REF_CLK); endclocking
	default disable iff (!RSTN);

	sequence s_commit_req_next;
		tx_commit[0] && !tx_last_write[0] && !tx_hold_valid[0];
	endsequence

	sequence s_commit_req_last;
		tx_commit[0] && tx_last_write[0] && !tx_hold_valid[0];
	endsequence

	a_req_next_push: assert property (s_commit_req_next |=> g_tx[0].hold_valid
		&& !g_tx[0].hold.last && g_tx[0].hold.data == $past(commit_word)) // [RL1]
		else $error("request next quadlet not held as middle quadlet");
	a_req_last_push: assert property (s_commit_req_last |=> g_tx[0].hold_valid
		&& g_tx[0].hold.last && g_tx[0].hold.data == $past(commit_word)) // [RL2]
		else $error("request last quadlet not held as closing quadlet");
	a_req_written_clear: assert property (tx_commit[0] && !tx_move[0]
		|=> !flags[BIT_TX_WRITTEN]) // [RL3]
		else $error("request written flag not cleared by write");
	a_rsp_written_clear: assert property (tx_commit[1] && !tx_move[1]
		|=> !flags[BIT_TX_WRITTEN + 1] && g_tx[1].hold_valid) // [RL4]
		else $error("response write did not clear written flag");
	a_rsp_last_push: assert property (tx_commit[1] && tx_last_write[1] && !tx_hold_valid[1]
		|=> g_tx[1].hold.last) // [RL5]
		else $error("response last quadlet not marked closing");
	a_written_set: assert property (tx_move[0] |=> flags[BIT_TX_WRITTEN]
		##0 (g_tx[0].count != 2'h0)) // [RL16]
		else $error("written flag not set after transfer");
	a_req_read_clear: assert property (rx_read_done[0] && !rx_load[0]
		|=> !flags[BIT_RX_READY] && RX_READY[0] == !flags[BIT_RX_FAULT]) // [RL6]
		else $error("request read did not clear ready flag");
	a_rsp_read_clear: assert property (rx_read_done[1] && !rx_load[1]
		|=> !flags[BIT_RX_READY + 1]) // [RL7]
		else $error("response read did not clear ready flag");
	a_rx_load_ready: assert property (rx_load[1] |=> flags[BIT_RX_READY + 1]
		&& !RX_READY[1] && rx_word[1] == $past(RX_QUADLET[1].data)) // [RL12]
		else $error("response load did not raise ready");
	a_fault_blocks: assert property (BUS_RESET |=> flags[BIT_RX_FAULT]
		&& flags[BIT_RX_FAULT + 1] && RX_READY == 2'h0) // [RL11]
		else $error("bus reset did not block receive reads");
	a_full_edge: assert property ($rose(RX_QUEUE_FULL[0]) |=> flags[BIT_RX_FULL]) // [RL8]
		else $error("receive request full not latched");
	a_timeout_set: assert property (ev_set[BIT_TIMEOUT] |=> flags[BIT_TIMEOUT]
		&& !running) // [RL13]
		else $error("timeout not flagged at expiry");
	a_reply_set: assert property (ev_set[BIT_REPLY] |=> flags[BIT_REPLY]
		&& !running) // [RL14]
		else $error("solicited reply not flagged");
	a_int_level: assert property (##1 HIF_INT_N == !(|($past(flags) & $past(enables)))) // [RL20]
		else $error("interrupt does not follow flags and enables");

endmodule

// ===== test/aqh_queue_model.sv
// Behavioural model of the link layer queue logic behind the host port
`timescale 1ns/100ps
module aqh_queue_model
	import aqh_pkg::*;
(
	// Clock and reset
	input  wire logic                clk,
	input  wire logic                rstn,
	// Transmit side, sink
	input  wire aqh_txq_type [1:0]   tx_q,
	input  wire logic [1:0]          tx_valid,
	output logic [1:0]               tx_ready,
	// Receive side, source
	output aqh_rxq_type [1:0]        rx_q,
	output logic [1:0]               rx_valid,
	input  wire logic [1:0]          rx_ready
);
	aqh_txq_type got [2][$];
	aqh_rxq_type pend [2][$];
	logic        phase;
	//==========================================================
	// Queue behaviour
	// Ready only every other cycle, so the port buffer must hold words;
	// plain always since the bench also pushes and pops these queues
	always @(posedge clk) begin
		phase <= !phase && rstn;
		tx_ready <= {2{phase}};
		for (int c = 0; c < 2; c++) begin
			if (!rstn) begin
				rx_valid[c] <= 1'b0;
			end else begin
				if (tx_valid[c] && tx_ready[c]) got[c].push_back(tx_q[c]);
				if (rx_valid[c] && rx_ready[c]) void'(pend[c].pop_front());
				rx_valid[c] <= pend[c].size() != 0;
				// Idle lines toggle so a stale word never looks valid
				rx_q[c] <= (pend[c].size() != 0) ? pend[c][0] : ~rx_q[c];
			end
		end
	end
endmodule

// ===== test/testbench.sv
// Self-checking testbench of the asynchronous queue host port
`timescale 1ns/100ps
module testbench;
	import aqh_pkg::*;
	logic              clk = 1'b0;
	logic              rstn = 1'b0;
	logic [8:0]        addr = 9'h000;
	logic              cs_n = 1'b1;
	logic              wr_n = 1'b1;
	logic              rd_n = 1'b1;
	logic [7:0]        din = 8'h00;
	logic [7:0]        dout;
	logic              int_n;
	logic              oe_n;
	aqh_txq_type [1:0] tx_q;
	logic [1:0]        tx_valid;
	logic [1:0]        tx_ready;
	aqh_rxq_type [1:0] rx_q;
	logic [1:0]        rx_valid;
	logic [1:0]        rx_ready;
	logic [1:0]        tx_full = 2'h0;
	logic [1:0]        tx_err = 2'h0;
	logic [1:0]        rx_full = 2'h0;
	logic [1:0]        rx_err = 2'h0;
	logic              bus_rst = 1'b0;
	logic              split = 1'b0;
	logic              reply = 1'b0;
	logic [2:0]        secs = 3'h0;
	logic [12:0]       frac = 13'h0000;
	logic [31:0]       v;
	int                err_count = 0;
	int                n_checks = 0;
	//==========================================================
	// Clock, design and queue model
	always #2 clk = !clk;
	aqh_port #(.TICK_CYCLES(4)) u_dut (.REF_CLK(clk), .RSTN(rstn), .HIF_ADDR(addr),
		.HIF_CS_N(cs_n), .HIF_WR_N(wr_n), .HIF_RD_N(rd_n), .HIF_DATA_IN(din),
		.HIF_DATA_OUT(dout), .HIF_DATA_OE_N(oe_n), .HIF_INT_N(int_n), .TX_QUADLET(tx_q),
		.TX_VALID(tx_valid), .TX_READY(tx_ready), .TX_QUEUE_FULL(tx_full),
		.TX_WRITE_ERROR(tx_err), .RX_QUADLET(rx_q), .RX_VALID(rx_valid), .RX_READY(rx_ready),
		.RX_QUEUE_FULL(rx_full), .RX_READ_ERROR(rx_err), .BUS_RESET(bus_rst),
		.SPLIT_START(split), .SOLICITED_REPLY(reply), .TIMEOUT_WHOLE_SECONDS(secs),
		.TIMEOUT_FRACTION_TICKS(frac));
	aqh_queue_model u_model (.clk(clk), .rstn(rstn), .tx_q(tx_q), .tx_valid(tx_valid),
		.tx_ready(tx_ready), .rx_q(rx_q), .rx_valid(rx_valid), .rx_ready(rx_ready));
	//==========================================================
	// Reporting
	task automatic check(input logic [32:0] seen, input logic [32:0] exp);
		n_checks++;
		if (seen !== exp) begin
			$display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
			err_count++;
		end
	endtask
	task automatic final_report();
		$display("checks=%0d mismatches=%0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	//==========================================================
	// Host bus cycles; strobes held four cycles to clear the synchronisers
	task automatic bus(input logic [8:0] a, input logic wr, input logic [7:0] d,
		output logic [7:0] q);
		@(negedge clk);
		addr = a;
		din = d;
		cs_n = 1'b0;
		wr_n = !wr;
		rd_n = wr;
		repeat (4) @(negedge clk);
		q = dout;
		if (!wr) check(33'(oe_n), 33'h0);
		cs_n = 1'b1;
		wr_n = 1'b1;
		rd_n = 1'b1;
		repeat (4) @(negedge clk);
	endtask
	task automatic wq(input logic [8:0] a, input logic [31:0] d);
		logic [7:0] q;
		for (int l = 0; l < 4; l++) bus(a + 9'(l), 1'b1, d[8*l +: 8], q);
	endtask
	task automatic rq(input logic [8:0] a, output logic [31:0] d);
		for (int l = 0; l < 4; l++) bus(a + 9'(l), 1'b0, 8'h00, d[8*l +: 8]);
	endtask
	task automatic fl(input logic [31:0] e);
		logic [31:0] f;
		rq(OFS_FLAGS, f);
		check(33'(f), 33'(e));
	endtask
	task automatic pulse(ref logic [1:0] s, input logic [1:0] val);
		@(negedge clk);
		s = val;
		@(negedge clk);
		s = 2'h0;
	endtask
	//==========================================================
	// Hang guard
	initial begin
		repeat (100000) @(posedge clk);
		err_count++;
		final_report();
	end
	//==========================================================
	// Main sequence
	initial begin
		repeat (12) @(negedge clk);
		rstn = 1'b1;
		repeat (4) @(negedge clk);
		fl(32'h00000000);
		rq(OFS_ENABLES, v);
		check(33'(v), 33'h0);
		rq(OFS_RXREQ, v);
		check(33'(v), 33'h0);
		check(33'(int_n), 33'h1);
		$display("test reset done");
		// Each transfer register, written flag cleared first
		for (int i = 0; i < 4; i++) begin
			wq(OFS_FLAGS, 32'hFFFFFFFF);
			wq(OFS_TXREQ_NEXT + 9'(4 * i), 32'hA0B1C2D0 + 32'(i));
			repeat (6) @(negedge clk);
			fl(32'h1 << (i / 2));
			check(33'(u_model.got[i / 2].pop_front()), {i[0], 32'hA0B1C2D0 + 32'(i)});
		end
		$display("test transmit done");
		// Receive quadlets on both queues
		wq(OFS_FLAGS, 32'hFFFFFFFF);
		u_model.pend[0].push_back({1'b1, 1'b1, 32'h13572468});
		u_model.pend[1].push_back({1'b0, 1'b1, 32'h2468ACE0});
		repeat (6) @(negedge clk);
		fl(32'h00007300);
		rq(OFS_RXREQ, v);
		check(33'(v), 33'h13572468);
		rq(OFS_RXRSP, v);
		check(33'(v), 33'h2468ACE0);
		fl(32'h00007000);
		$display("test receive done");
		// Read fault blocks the queue until cleared
		wq(OFS_FLAGS, 32'hFFFFFFFF);
		pulse(rx_err, 2'h1);
		u_model.pend[0].push_back({1'b0, 1'b0, 32'h0F1E2D3C});
		repeat (6) @(negedge clk);
		fl(32'h00000400);
		rq(OFS_RXREQ, v);
		check(33'(v), 33'h0);
		@(negedge clk);
		bus_rst = 1'b1;
		@(negedge clk);
		bus_rst = 1'b0;
		fl(32'h00000C00);
		wq(OFS_FLAGS, 32'hFFFFFFFF);
		repeat (6) @(negedge clk);
		fl(32'h00000100);
		rq(OFS_RXREQ, v);
		check(33'(v), 33'h0F1E2D3C);
		$display("test fault done");
		// Queue full edges and transmit write faults
		wq(OFS_FLAGS, 32'hFFFFFFFF);
		@(negedge clk);
		tx_full = 2'h3;
		rx_full = 2'h3;
		pulse(tx_err, 2'h3);
		repeat (4) @(negedge clk);
		fl(32'h0001803C);
		tx_full = 2'h0;
		rx_full = 2'h0;
		$display("test full done");
		// Split timer: expiry, reply in time, whole-second limit
		wq(OFS_FLAGS, 32'hFFFFFFFF);
		frac = 13'h0002;
		@(negedge clk);
		split = 1'b1;
		@(negedge clk);
		split = 1'b0;
		repeat (30) @(negedge clk);
		fl(32'h00000080);
		wq(OFS_FLAGS, 32'hFFFFFFFF);
		split = 1'b1;
		@(negedge clk);
		split = 1'b0;
		repeat (2) @(negedge clk);
		reply = 1'b1;
		@(negedge clk);
		reply = 1'b0;
		repeat (30) @(negedge clk);
		fl(32'h00000040);
		wq(OFS_FLAGS, 32'hFFFFFFFF);
		secs = 3'h1;
		frac = 13'h0000;
		split = 1'b1;
		@(negedge clk);
		split = 1'b0;
		repeat (31900) @(negedge clk);
		fl(32'h00000000);
		repeat (200) @(negedge clk);
		fl(32'h00000080);
		$display("test timer done");
		// Interrupt follows flag and enable
		wq(OFS_ENABLES, 32'hFFFFFFFF);
		repeat (4) @(negedge clk);
		check(33'(int_n), 33'h0);
		rq(OFS_ENABLES, v);
		check(33'(v), 33'h0001FFFF);
		wq(OFS_FLAGS, 32'hFFFFFFFF);
		repeat (4) @(negedge clk);
		check(33'(int_n), 33'h1);
		$display("test interrupt done");
		final_report();
	end
endmodule
